// ---- rtl/lcg_gate34_sel.sv ----
module lcg_gate34_sel (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Data selector copies, same clock domain
   input  wire logic        data_in1_true,
   input  wire logic        data_in1_inverted,
   input  wire logic        data_in2_true,
   input  wire logic        data_in2_inverted,
   input  wire logic        data_in3_true,
   input  wire logic        data_in3_inverted,
   input  wire logic        data_in4_true,
   input  wire logic        data_in4_inverted,
   // Gate outputs
   output logic             gate_three_out,
   output logic             gate_four_out
);
   localparam int SW = lcg_pkg::SEL_W;

   logic [SW-1:0] gate3_input_select_ff, nxt_gate3_input_select;
   logic [SW-1:0] gate4_input_select_ff, nxt_gate4_input_select;
   logic          aw_held_ff, nxt_aw_held;
   logic [3:0]    aw_addr_ff, nxt_aw_addr;
   logic          w_held_ff, nxt_w_held;
   logic [31:0]   w_data_ff, nxt_w_data;
   logic [3:0]    w_strb_ff, nxt_w_strb;
   logic          bvalid_ff, nxt_bvalid;
   logic [1:0]    bresp_ff, nxt_bresp;
   logic          rvalid_ff, nxt_rvalid;
   logic [1:0]    rresp_ff, nxt_rresp;
   logic [31:0]   rdata_ff, nxt_rdata;
   logic          g3_ff, nxt_g3;
   logic          g4_ff, nxt_g4;
   logic [3:0]    din_true, din_inv;
   logic          g3_comb, g4_comb;
   logic          do_write;
   logic          awready_ff, nxt_awready;
   logic          wready_ff, nxt_wready;
   logic          arready_ff, nxt_arready;

   function automatic logic is_g3(input logic [3:0] a);
      return a == lcg_pkg::OFF_G3_SEL;
   endfunction
   function automatic logic is_g4(input logic [3:0] a);
      return a == lcg_pkg::OFF_G4_SEL;
   endfunction

   assign din_true = {data_in4_true, data_in3_true, data_in2_true, data_in1_true};
   assign din_inv  = {data_in4_inverted, data_in3_inverted, data_in2_inverted, data_in1_inverted};

   // input 2 true via bit 3
   lcg_gate_or #(.N(lcg_pkg::N_IN)) u_g3 (
      .sel      (gate3_input_select_ff),
      .din_true (din_true),
      .din_inv  (din_inv),
      .gate     (g3_comb)
   );
   lcg_gate_or #(.N(lcg_pkg::N_IN)) u_g4 (
      .sel      (gate4_input_select_ff),
      .din_true (din_true),
      .din_inv  (din_inv),
      .gate     (g4_comb)
   );

   assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_held  = w_held_ff;
      nxt_w_data  = w_data_ff;
      nxt_w_strb  = w_strb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_gate3_input_select = gate3_input_select_ff;
      nxt_gate4_input_select = gate4_input_select_ff;
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
         nxt_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
         nxt_w_data = s_axi_wdata;
         nxt_w_strb = s_axi_wstrb;
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (do_write) begin
         nxt_aw_held = 1'b0;
         nxt_w_held  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = lcg_pkg::RESP_OKAY;
         if (is_g3(aw_addr_ff)) begin
            if (w_strb_ff[0]) begin
               nxt_gate3_input_select = w_data_ff[SW-1:0];
            end
         end else if (is_g4(aw_addr_ff)) begin
            if (w_strb_ff[0]) begin
               nxt_gate4_input_select = w_data_ff[SW-1:0];
            end
         end else begin
            nxt_bresp = lcg_pkg::RESP_SLVERR;
         end
      end
   end

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rresp  = rresp_ff;
      nxt_rdata  = rdata_ff;
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = lcg_pkg::RESP_OKAY;
         nxt_rdata  = 32'h0000_0000;
         if (is_g3(s_axi_araddr)) begin
            nxt_rdata[SW-1:0] = gate3_input_select_ff;
         end else if (is_g4(s_axi_araddr)) begin
            nxt_rdata[SW-1:0] = gate4_input_select_ff;
         end else begin
            nxt_rresp = lcg_pkg::RESP_SLVERR;
         end
      end
   end

   always_comb begin
      nxt_g3 = g3_comb;
      nxt_g4 = g4_comb;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate3_input_select_ff <= lcg_pkg::SEL_RESET;
         gate4_input_select_ff <= lcg_pkg::SEL_RESET;
         aw_held_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_held_ff  <= 1'b0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= 2'h0;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= 2'h0;
         rdata_ff   <= 32'h0000_0000;
         g3_ff      <= 1'b0;
         g4_ff      <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         arready_ff <= 1'b0;
      end else begin
         gate3_input_select_ff <= nxt_gate3_input_select;
         gate4_input_select_ff <= nxt_gate4_input_select;
         aw_held_ff <= nxt_aw_held;
         aw_addr_ff <= nxt_aw_addr;
         w_held_ff  <= nxt_w_held;
         w_data_ff  <= nxt_w_data;
         w_strb_ff  <= nxt_w_strb;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         rvalid_ff  <= nxt_rvalid;
         rresp_ff   <= nxt_rresp;
         rdata_ff   <= nxt_rdata;
         g3_ff      <= nxt_g3;
         g4_ff      <= nxt_g4;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         arready_ff <= nxt_arready;
      end
   end

   // Ready flops track a free slot, low through reset
   always_comb begin
      nxt_awready = !nxt_aw_held;
      nxt_wready  = !nxt_w_held;
      nxt_arready = !nxt_rvalid;
   end
   assign s_axi_awready  = awready_ff;
   assign s_axi_wready   = wready_ff;
   assign s_axi_arready  = arready_ff;
   assign s_axi_bvalid   = bvalid_ff;
   assign s_axi_bresp    = bresp_ff;
   assign s_axi_rvalid   = rvalid_ff;
   assign s_axi_rresp    = rresp_ff;
   assign s_axi_rdata    = rdata_ff;
   assign gate_three_out = g3_ff;
   assign gate_four_out  = g4_ff;
endmodule // lcg_gate34_sel

// ---- rtl/lcg_gate_or.sv ----
module lcg_gate_or #(
   parameter int N = 4
) (
   // Select and data
   input  wire logic [2*N-1:0] sel,
   input  wire logic [N-1:0]   din_true,
   input  wire logic [N-1:0]   din_inv,
   // Result
   output logic                gate
);
   logic [2*N-1:0] terms;

   // Refuse a gate without inputs
   if (N < 1) begin : g_bad_n
      $error("lcg_gate_or needs at least one input");
   end
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_in
         assign terms[2*i+lcg_pkg::TRUE_BIT_BASE] = sel[2*i+lcg_pkg::TRUE_BIT_BASE] & din_true[i];
         assign terms[2*i] = sel[2*i] & din_inv[i];
      end
   endgenerate
   assign gate = |terms;
endmodule // lcg_gate_or

// ---- rtl/lcg_pkg.sv ----
package lcg_pkg;
   localparam int          ADDR_W            = 4;
   localparam int          DATA_W            = 32;
   localparam int          SEL_W             = 8;
   localparam int          N_IN              = 4;
   localparam logic [ADDR_W-1:0] OFF_G3_SEL  = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_G4_SEL  = 4'h4;
   localparam logic [SEL_W-1:0]  SEL_RESET   = 8'h00;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;
   // Bit position of the true-select for input n (0-based); inverted is one below
   localparam int          TRUE_BIT_BASE     = 1;
endpackage

// ---- tb/lcg_chk_properties.sv ----
module lcg_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        data_in1_true,
   input wire logic        data_in1_inverted,
   input wire logic        data_in2_true,
   input wire logic        data_in2_inverted,
   input wire logic        data_in3_true,
   input wire logic        data_in3_inverted,
   input wire logic        data_in4_true,
   input wire logic        data_in4_inverted,
   input wire logic        gate_three_out,
   input wire logic        gate_four_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] s3_ff, s4_ff, w_ff, v;
   logic [3:0] a_ff;
   logic       ws_ff, t3_ff, n3_ff, t4_ff, n4_ff, x2_ff;
   assign v = {data_in4_true, data_in4_inverted, data_in3_true, data_in3_inverted,
               data_in2_true, data_in2_inverted, data_in1_true, data_in1_inverted};
   // Shadow of the select registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s3_ff <= 8'h0;
         s4_ff <= 8'h0;
      end else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == lcg_pkg::RESP_OKAY && ws_ff) begin
         if (a_ff == lcg_pkg::OFF_G3_SEL) s3_ff <= w_ff;
         if (a_ff == lcg_pkg::OFF_G4_SEL) s4_ff <= w_ff;
      end
      if (s_axi_awvalid && s_axi_awready) a_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
         w_ff  <= s_axi_wdata[7:0];
         ws_ff <= s_axi_wstrb[0];
      end
      t3_ff <= |(s3_ff & v & 8'haa);
      n3_ff <= |(s3_ff & v & 8'h55);
      t4_ff <= |(s4_ff & v & 8'haa);
      n4_ff <= |(s4_ff & v & 8'h55);
      x2_ff <= s3_ff[3] & data_in2_true;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_settled;
      !$past(s_axi_bvalid);
   endsequence
   property p_g3_true;
      s_settled ##0 t3_ff |-> gate_three_out;
   endproperty
   a_g3_true: assert property (p_g3_true) else $error("gate 3 missed true copy");
   property p_g3_inv;
      s_settled ##0 n3_ff |-> gate_three_out;
   endproperty
   a_g3_inv: assert property (p_g3_inv) else $error("gate 3 missed inverted copy");
   property p_g3_none;
      s_settled ##0 (!t3_ff && !n3_ff) |-> !gate_three_out;
   endproperty
   a_g3_none: assert property (p_g3_none) else $error("gate 3 high without copy");
   property p_g4_true;
      s_settled ##0 t4_ff |-> gate_four_out;
   endproperty
   a_g4_true: assert property (p_g4_true) else $error("gate 4 missed true copy");
   property p_g4_inv;
      s_settled ##0 n4_ff |-> gate_four_out;
   endproperty
   a_g4_inv: assert property (p_g4_inv) else $error("gate 4 missed inverted copy");
   property p_g3_in2;
      s_settled ##0 x2_ff |-> gate_three_out;
   endproperty
   a_g3_in2: assert property (p_g3_in2) else $error("gate 3 missed input 2");
   property p_g4_or;
      s_settled |-> gate_four_out == (t4_ff || n4_ff);
   endproperty
   a_g4_or: assert property (p_g4_or) else $error("gate 4 not the OR");
endmodule // lcg_chk

bind lcg_gate34_sel lcg_chk u_chk (.*);

// ---- tb/lcg_src_model.sv ----
module lcg_src_model (
   // Pattern from bench
   input  wire logic [3:0] pat,
   // Selector copies
   output logic [3:0]      d_true,
   output logic [3:0]      d_inv
);
   timeunit 1ns;
   timeprecision 1ps;
   assign d_true = pat;
   assign d_inv  = ~pat;
endmodule // lcg_src_model

// ---- tb/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, pat = 4'h0, dt, di;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        gate_three_out, gate_four_out;
   int          n_errors = 0, cmp_count = 0;
   lcg_src_model u_src (.pat(pat), .d_true(dt), .d_inv(di));
   lcg_gate34_sel dut (.*, .data_in1_true(dt[0]), .data_in1_inverted(di[0]), .data_in2_true(dt[1]),
      .data_in2_inverted(di[1]), .data_in3_true(dt[2]), .data_in3_inverted(di[2]),
      .data_in4_true(dt[3]), .data_in4_inverted(di[3]));
   initial forever #10 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      logic ta, tw, tb_;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      tb_ = 1'h0;
      while (!tb_) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb_ = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tb_) s_axi_bready <= 1'h0;
      end
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      tr = 1'h0;
      while (!tr) begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'h0;
         if (tr) s_axi_rready <= 1'h0;
      end
   endtask
   function automatic logic ex(input logic [7:0] s, input logic [3:0] p);
      return |(s & {p[3], ~p[3], p[2], ~p[2], p[1], ~p[1], p[0], ~p[0]});
   endfunction
   // All 16 data patterns against both gates
   task automatic sweep(input logic [7:0] s3, input logic [7:0] s4);
      for (int p = 0; p < 16; p++) begin
         @(posedge aclk);
         pat <= 4'(p);
         @(posedge aclk);
         @(negedge aclk);
         chk(gate_three_out, ex(s3, 4'(p)));
         chk(gate_four_out, ex(s4, 4'(p)));
      end
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      for (int r = 0; r < 2; r++) begin
         rd(4'(r * 4), rd_d, rs);
         chk(rd_d, 32'(lcg_pkg::SEL_RESET));
      end
      sweep(8'h0, 8'h0);
      $display("reset test done");
      for (int r = 0; r < 2; r++) begin
         for (int b = 0; b < 8; b++) begin
            wr(4'(r * 4), 8'h1 << b, rs);
            chk(rs, lcg_pkg::RESP_OKAY);
            rd(4'(r * 4), rd_d, rs);
            chk(rd_d, 32'h1 << b);
            sweep(r ? 8'h0 : 8'h1 << b, r ? 8'h1 << b : 8'h0);
         end
         wr(4'(r * 4), 8'h0, rs);
      end
      $display("bit walk test done");
      wr(4'h0, 8'haa, rs);
      wr(4'h4, 8'h55, rs);
      sweep(8'haa, 8'h55);
      wr(4'h8, 8'hff, rs);
      chk(rs, lcg_pkg::RESP_SLVERR);
      rd(4'h8, rd_d, rs);
      chk(rd_d, 32'h0);
      chk(rs, lcg_pkg::RESP_SLVERR);
      rd(4'h0, rd_d, rs);
      chk(rd_d, 32'haa);
      chk(rs, lcg_pkg::RESP_OKAY);
      // Write with byte 0 disabled must leave the register alone
      s_axi_wstrb <= 4'h0;
      wr(4'h0, 8'h33, rs);
      chk(rs, lcg_pkg::RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(4'h0, rd_d, rs);
      chk(rd_d, 32'haa);
      rd(4'h4, rd_d, rs);
      chk(rd_d, 32'h55);
      $display("or and unmapped test done");
      tally_and_finish;
   end
   initial begin
      #400000;
      n_errors++;
      tally_and_finish;
   end
endmodule // tb
